// ---- rtl/srp_pkg.sv ----
// Shared constants and types of the system reset and power-save controller
package srp_pkg;

  // Reset counter geometry
  localparam int unsigned              SRP_CNT_W        = 20;         // Width of the reset counter
  localparam logic [SRP_CNT_W-1:0]     SRP_LONG_CYCLES  = 20'h48000;  // Long delay, 294 912 cycles
  localparam logic [SRP_CNT_W-1:0]     SRP_SHORT_CYCLES = 20'h00120;  // Short delay, 288 cycles
  localparam logic [SRP_CNT_W-1:0]     SRP_SYNC_LAT     = 20'h00002;  // Cycles lost in the pin synchronisers

  // Register port geometry
  localparam int unsigned              SRP_ADDR_W       = 4;          // Register address width
  localparam int unsigned              SRP_DATA_W       = 8;          // Register data width

  // Register offsets
  localparam logic [SRP_ADDR_W-1:0]    SRP_REG_CMD      = 4'h0;       // Mode commands, write only
  localparam logic [SRP_ADDR_W-1:0]    SRP_REG_INHIBIT  = 4'h1;       // Correlator input inhibit mask
  localparam logic [SRP_ADDR_W-1:0]    SRP_REG_STATUS   = 4'h2;       // Live status, read only

  // Command register fields
  localparam int unsigned              SRP_CMD_SLEEP    = 0;          // Write 1 to start sleep entry
  localparam int unsigned              SRP_CMD_IDLE     = 1;          // Write 1 to enter idle

  // Status register fields
  localparam int unsigned              SRP_STS_RELEASED = 0;          // Internal reset released
  localparam int unsigned              SRP_STS_WARN     = 1;          // Power warning input is low
  localparam int unsigned              SRP_STS_FAIL     = 2;          // Power fail input is low
  localparam int unsigned              SRP_STS_SLEEP    = 3;          // Sleeping
  localparam int unsigned              SRP_STS_IDLE     = 4;          // Idling
  localparam int unsigned              SRP_STS_GATED    = 5;          // Sample inputs blocked
  localparam int unsigned              SRP_STS_RFREQ    = 6;          // Front-end power-down pending

  // Reset values
  localparam logic [SRP_DATA_W-1:0]    SRP_INHIBIT_RST  = 8'h00;      // All channels fed after reset
  localparam logic                     SRP_SYNC_RST     = 1'b0;       // Synchronisers read low in reset

  // Power-save sequencer states
  typedef enum logic [2:0] {
    SRP_RUN,
    SRP_RF_CMD,
    SRP_GATE,
    SRP_SLEEP,
    SRP_IDLE
  } srp_pwr_state_t;

endpackage

// ---- rtl/srp_reset_counter.sv ----
// Reset delay counter with asynchronous clear and selectable terminal count
`timescale 1ns/1ps
`default_nettype none
module srp_reset_counter
  import srp_pkg::*;
#(
  parameter int unsigned CNT_W = SRP_CNT_W    // Counter width
) (
  // Clock and asynchronous clear
  input  wire logic             clk_i,
  input  wire logic             clr_n_i,
  // Count control
  input  wire logic             en_i,
  input  wire logic             sel_long_i,
  input  wire logic [CNT_W-1:0] long_term_i,
  input  wire logic [CNT_W-1:0] short_term_i,
  // Result
  output logic                  done_o,
  output logic      [CNT_W-1:0] count_o
);

  typedef struct packed {
    logic [CNT_W-1:0] count;                  // Cycles counted since both monitors healthy
    logic             done;                   // Terminal count reached, sticky until clear
  } srp_cnt_st_t;

  srp_cnt_st_t      st_ff;                    // Registered state
  srp_cnt_st_t      nxt_st;                   // Next state
  logic [CNT_W-1:0] term;                     // Terminal value picked by the delay select

  // Decode: the select pin chooses which terminal value ends reset
  assign term = sel_long_i ? long_term_i : short_term_i;

  // Count while enabled, then hold so reset never re-asserts by wrap
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.done && en_i) begin
      nxt_st.count = st_ff.count + 1'b1;
      if (nxt_st.count >= term) begin
        nxt_st.done = 1'b1;
      end
    end
  end

  // Pin low clears the counter without waiting for a clock edge
  always_ff @(posedge clk_i or negedge clr_n_i) begin
    if (!clr_n_i) begin
      st_ff <= '{count: '0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o  = st_ff.done;
  assign count_o = st_ff.count;

  // Once done, count and done stay frozen
  property p_done_hold;
    @(posedge clk_i) disable iff (!clr_n_i)
    done_o |=> done_o && $stable(count_o);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("reset counter moved after terminal count");

  // Without enable the count does not move
  property p_count_gated;
    @(posedge clk_i) disable iff (!clr_n_i)
    (!en_i && !done_o) |=> $stable(count_o);
  endproperty
  a_count_gated: assert property (p_count_gated) else $error("reset counter ran while disabled");

  // Done rises exactly on the selected terminal value
  property p_term_hit;
    @(posedge clk_i) disable iff (!clr_n_i)
    ($rose(done_o) && $stable(sel_long_i)) |-> (count_o == term);
  endproperty
  a_term_hit: assert property (p_term_hit) else $error("reset released at wrong count");

endmodule
`default_nettype wire

// ---- rtl/srp_reset_power_ctrl.sv ----
// Top of the system reset controller and power-save sequencer
//
// What this block does
// - Twenty-bit reset counter, system clock, async clear.
// - Power fail low clears counter immediately.
// - Counter runs only while both monitors high.
// - Delay select picks decoded terminal count.
// - Release after 294912 or 288 cycles.
// - Reset holds processor and all registers.
// - Reset frees data bus, drops strobes.
// - Reset makes GPIO inputs, oscillator enabled.
// - Watchdog may also reset the processor.
// - Per-channel correlator input inhibit by firmware.
// - Sleep: front-end command, gate inputs, then halt.
// - Sleep blocks reference clock and IF pins.
// - Any hardware interrupt ends sleep.
// - Sleep leaves real-time clock running.
// - Interrupt ends idle, processor resumes.
// - Idle keeps output pins, does nothing else.
// - Idle leaves sample inputs ungated.
// - Power warning low interrupts the processor.
// - Power fail low: reset, isolate RTC, RAM deselect.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module srp_reset_power_ctrl
  import srp_pkg::*;
#(
  parameter logic [SRP_CNT_W-1:0] LONG_DELAY_CYCLES  = SRP_LONG_CYCLES,  // Long reset delay in cycles
  parameter logic [SRP_CNT_W-1:0] SHORT_DELAY_CYCLES = SRP_SHORT_CYCLES, // Short reset delay in cycles
  parameter int unsigned          CHAN_W             = 8,                // Correlator channels
  parameter int unsigned          GPIO_W             = 8,                // General purpose pins
  parameter int unsigned          IRQ_W              = 4                 // Wake interrupt lines
) (
  // Clock and synchronous reset
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  RST_I,
  // Supply monitor and delay select pins
  input  wire logic                  POWER_FAIL_N_I,
  input  wire logic                  POWER_WARNING_N_I,
  input  wire logic                  RESET_DELAY_SELECT_I,
  // Watchdog
  input  wire logic                  WATCHDOG_RESET_I,
  // Register port
  input  wire logic [SRP_ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [SRP_DATA_W-1:0] REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic      [SRP_DATA_W-1:0] REG_RDATA_O,
  // Wake sources from peripherals
  input  wire logic [IRQ_W-1:0]      WAKE_IRQ_I,
  // Front-end power-down command handshake
  output logic                       RF_POWER_DOWN_REQ_O,
  input  wire logic                  RF_POWER_DOWN_DONE_I,
  // Processor control
  output logic                       CORE_RESET_O,
  output logic                       REGS_RESET_O,
  output logic                       CORE_HALT_O,
  output logic                       POWER_WARNING_IRQ_O,
  // Pad requests from the processor
  input  wire logic                  BUS_DRIVE_REQ_I,
  input  wire logic                  RD_STROBE_REQ_I,
  input  wire logic                  WR_STROBE_REQ_I,
  input  wire logic [GPIO_W-1:0]     GPIO_OE_REQ_I,
  // Pad controls
  output logic                       BUS_OE_O,
  output logic                       RD_STROBE_O,
  output logic                       WR_STROBE_O,
  output logic      [GPIO_W-1:0]     GPIO_OE_O,
  output logic                       OSC_ENABLE_O,
  // Front-end input gating
  output logic                       SAMPLE_INPUT_BLOCK_O,
  output logic      [CHAN_W-1:0]     CHANNEL_INHIBIT_O,
  // Backup domain
  input  wire logic                  BACKUP_RAM_SELECT_REQ_N_I,
  output logic                       BACKUP_RAM_SELECT_N_O,
  output logic                       RTC_ISOLATE_O
);

  // Whole state of the sequencer and register file
  typedef struct packed {
    srp_pwr_state_t  pstate;                  // Power-save sequencer state
    logic [CHAN_W-1:0] inhibit;               // Correlator input inhibit mask
    logic            gate;                    // Sample inputs blocked
    logic            halt;                    // Processor halted
    logic            rf_req;                  // Front-end power-down command pending
    logic [SRP_DATA_W-1:0] rdata;             // Read data, valid one cycle after read
  } srp_st_t;

  localparam srp_st_t st_rst = '{
    pstate:  SRP_RUN,
    inhibit: SRP_INHIBIT_RST[CHAN_W-1:0],
    gate:    1'b0,
    halt:    1'b0,
    rf_req:  1'b0,
    rdata:   '0
  };

  srp_st_t                 st_ff;             // Registered state
  srp_st_t                 nxt_st;            // Next state
  logic                    fail_s;            // Power fail pin, synchronised
  logic                    warn_s;            // Power warning pin, synchronised
  logic                    sel_s;             // Delay select pin, synchronised
  logic                    cnt_done;          // Counter reached terminal value
  logic [SRP_CNT_W-1:0]    term_long;         // Long terminal, sync latency removed
  logic [SRP_CNT_W-1:0]    term_short;        // Short terminal, sync latency removed
  logic                    regs_reset;        // Internal reset of all registers
  logic                    any_irq;           // Some wake source active
  logic                    sleep_cmd;         // Firmware asks for sleep
  logic                    idle_cmd;          // Firmware asks for idle
  logic [SRP_DATA_W-1:0]   status;            // Status word as read
  logic [SRP_DATA_W-1:0]   inhibit_rd;        // Inhibit mask widened for reading

  // Pin levels pass two flops before the enable, select and status logic read them; the fail pin is also used raw
  srp_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (RST_I),
    .d_i   ({POWER_FAIL_N_I, POWER_WARNING_N_I, RESET_DELAY_SELECT_I}),
    .q_o   ({fail_s, warn_s, sel_s})
  );

  // The synchroniser costs two cycles, so the decode ends two counts early
  assign term_long  = LONG_DELAY_CYCLES - SRP_SYNC_LAT;
  assign term_short = SHORT_DELAY_CYCLES - SRP_SYNC_LAT;

  // Raw pin clears the counter; the healthy pair enables it
  srp_reset_counter #(
    .CNT_W (SRP_CNT_W)
  ) u_counter (
    .clk_i        (CORE_CLK_I),
    .clr_n_i      (POWER_FAIL_N_I),
    .en_i         (fail_s & warn_s),
    .sel_long_i   (sel_s),
    .long_term_i  (term_long),
    .short_term_i (term_short),
    .done_o       (cnt_done),
    .count_o      ()
  );

  // Reset asserts at once with the pin and releases on a clock edge
  assign regs_reset   = ~cnt_done | RST_I;
  assign REGS_RESET_O = regs_reset;
  // Watchdog only touches the processor, not the rest of the chip
  assign CORE_RESET_O = regs_reset | WATCHDOG_RESET_I;

  // Warning is a level interrupt for the power-fail routine
  assign POWER_WARNING_IRQ_O = ~warn_s;

  // Pad direction and strobes are forced safe while in reset
  assign BUS_OE_O     = BUS_DRIVE_REQ_I & ~regs_reset;
  assign RD_STROBE_O  = RD_STROBE_REQ_I & ~regs_reset;
  assign WR_STROBE_O  = WR_STROBE_REQ_I & ~regs_reset;
  assign GPIO_OE_O    = GPIO_OE_REQ_I & {GPIO_W{~regs_reset}};
  // Oscillator is never stopped here, so it is always on in reset
  assign OSC_ENABLE_O = 1'b1;

  // Backup domain reacts to the raw pin: no clock may be trusted then
  assign BACKUP_RAM_SELECT_N_O = BACKUP_RAM_SELECT_REQ_N_I | ~POWER_FAIL_N_I;
  // Sleep never isolates the RTC; only power fail does
  assign RTC_ISOLATE_O         = ~POWER_FAIL_N_I;

  // Sequencer outputs come straight from state flops
  assign SAMPLE_INPUT_BLOCK_O = st_ff.gate;
  assign CORE_HALT_O          = st_ff.halt;
  assign RF_POWER_DOWN_REQ_O  = st_ff.rf_req;
  assign CHANNEL_INHIBIT_O    = st_ff.inhibit;
  assign REG_RDATA_O          = st_ff.rdata;

  // Wake sources: peripheral lines plus the power warning
  assign any_irq = (|WAKE_IRQ_I) | ~warn_s;

  // Command decode, taken only in the write cycle
  assign sleep_cmd = REG_WR_I && (REG_ADDR_I == SRP_REG_CMD) && REG_WDATA_I[SRP_CMD_SLEEP];
  assign idle_cmd  = REG_WR_I && (REG_ADDR_I == SRP_REG_CMD) && REG_WDATA_I[SRP_CMD_IDLE];

  // Status word assembled from live state
  always_comb begin
    status                   = '0;
    status[SRP_STS_RELEASED] = cnt_done;
    status[SRP_STS_WARN]     = ~warn_s;
    status[SRP_STS_FAIL]     = ~fail_s;
    status[SRP_STS_SLEEP]    = (st_ff.pstate == SRP_SLEEP);
    status[SRP_STS_IDLE]     = (st_ff.pstate == SRP_IDLE);
    status[SRP_STS_GATED]    = st_ff.gate;
    status[SRP_STS_RFREQ]    = st_ff.rf_req;
    inhibit_rd               = '0;
    inhibit_rd[CHAN_W-1:0]   = st_ff.inhibit;
  end

  // Register access and power-save sequencing
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = '0;
    // Read data stands only in the cycle after the strobe
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        SRP_REG_INHIBIT: nxt_st.rdata = inhibit_rd;
        SRP_REG_STATUS:  nxt_st.rdata = status;
        default:         nxt_st.rdata = '0;
      endcase
    end
    // Inhibit mask is free to change in any mode
    if (REG_WR_I && (REG_ADDR_I == SRP_REG_INHIBIT)) begin
      nxt_st.inhibit = REG_WDATA_I[CHAN_W-1:0];
    end
    case (st_ff.pstate)
      SRP_RUN: begin
        // Sleep wins if both commands arrive in one write
        if (sleep_cmd) begin
          nxt_st.rf_req = 1'b1;
          nxt_st.pstate = SRP_RF_CMD;
        end else if (idle_cmd) begin
          // Idle only halts; pads and gating are left alone
          nxt_st.halt   = 1'b1;
          nxt_st.pstate = SRP_IDLE;
        end
      end
      SRP_RF_CMD: begin
        // Inputs stay open until the front-end has its command
        if (RF_POWER_DOWN_DONE_I) begin
          nxt_st.rf_req = 1'b0;
          nxt_st.gate   = 1'b1;
          nxt_st.pstate = SRP_GATE;
        end
      end
      SRP_GATE: begin
        // Halt one cycle after gating so the order is visible
        nxt_st.halt   = 1'b1;
        nxt_st.pstate = SRP_SLEEP;
      end
      SRP_SLEEP: begin
        if (any_irq) begin
          nxt_st.gate   = 1'b0;
          nxt_st.halt   = 1'b0;
          nxt_st.pstate = SRP_RUN;
        end
      end
      SRP_IDLE: begin
        // Releasing halt lets the core carry on where it stopped
        if (any_irq) begin
          nxt_st.halt   = 1'b0;
          nxt_st.pstate = SRP_RUN;
        end
      end
      default: begin
        nxt_st.gate   = 1'b0;
        nxt_st.halt   = 1'b0;
        nxt_st.rf_req = 1'b0;
        nxt_st.pstate = SRP_RUN;
      end
    endcase
  end

  // Internal reset returns every register to its reset value
  always_ff @(posedge CORE_CLK_I) begin
    if (regs_reset) begin
      st_ff <= st_rst;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Power fail low forces both resets at once
  property p_fail_reset;
    @(posedge CORE_CLK_I)
    !POWER_FAIL_N_I |-> (CORE_RESET_O && REGS_RESET_O);
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("power fail did not force reset");

  // Power fail low deselects RAM and isolates RTC
  property p_fail_backup;
    @(posedge CORE_CLK_I)
    !POWER_FAIL_N_I |-> (BACKUP_RAM_SELECT_N_O && RTC_ISOLATE_O);
  endproperty
  a_fail_backup: assert property (p_fail_backup) else $error("backup domain not protected");

  // Bus and strobes are quiet in reset whatever the core asks
  property p_reset_bus;
    @(posedge CORE_CLK_I)
    REGS_RESET_O |-> (!BUS_OE_O && !RD_STROBE_O && !WR_STROBE_O);
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("bus driven during reset");

  // GPIO are inputs and the oscillator runs in reset
  property p_reset_gpio;
    @(posedge CORE_CLK_I)
    REGS_RESET_O |-> ((GPIO_OE_O == '0) && OSC_ENABLE_O);
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("GPIO or oscillator wrong in reset");

  // Watchdog resets the processor
  property p_watchdog;
    @(posedge CORE_CLK_I)
    WATCHDOG_RESET_I |-> CORE_RESET_O;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog did not reset core");

  // Gating comes before the halt, one cycle apart
  property p_sleep_order;
    @(posedge CORE_CLK_I) disable iff (REGS_RESET_O)
    $rose(SAMPLE_INPUT_BLOCK_O) |-> (!CORE_HALT_O && !RF_POWER_DOWN_REQ_O) ##1 CORE_HALT_O;
  endproperty
  a_sleep_order: assert property (p_sleep_order) else $error("sleep entry out of order");

  // Command goes out while inputs are still open
  property p_rf_first;
    @(posedge CORE_CLK_I) disable iff (REGS_RESET_O)
    $rose(RF_POWER_DOWN_REQ_O) |-> (!SAMPLE_INPUT_BLOCK_O && !CORE_HALT_O);
  endproperty
  a_rf_first: assert property (p_rf_first) else $error("front-end command after gating");

  // Interrupt in sleep ends it in the next cycle
  property p_sleep_wake;
    @(posedge CORE_CLK_I) disable iff (REGS_RESET_O)
    (CORE_HALT_O && SAMPLE_INPUT_BLOCK_O && (|WAKE_IRQ_I)) |=> (!CORE_HALT_O && !SAMPLE_INPUT_BLOCK_O);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not ended by interrupt");

  // Interrupt in idle releases the halt
  property p_idle_wake;
    @(posedge CORE_CLK_I) disable iff (REGS_RESET_O)
    (st_ff.pstate == SRP_IDLE && (|WAKE_IRQ_I)) |=> !CORE_HALT_O;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not ended by interrupt");

  // Idle never gates the sample inputs
  property p_idle_open;
    @(posedge CORE_CLK_I) disable iff (REGS_RESET_O)
    (st_ff.pstate == SRP_IDLE) |-> !SAMPLE_INPUT_BLOCK_O;
  endproperty
  a_idle_open: assert property (p_idle_open) else $error("inputs gated in idle");

  // RTC isolation follows only the power fail pin
  property p_rtc_free;
    @(posedge CORE_CLK_I)
    POWER_FAIL_N_I |-> !RTC_ISOLATE_O;
  endproperty
  a_rtc_free: assert property (p_rtc_free) else $error("RTC isolated without power fail");

  // Warning low for three samples raises the interrupt
  property p_warn_irq;
    @(posedge CORE_CLK_I) disable iff (RST_I)
    (!POWER_WARNING_N_I)[*3] |-> POWER_WARNING_IRQ_O;
  endproperty
  a_warn_irq: assert property (p_warn_irq) else $error("power warning interrupt missing");

endmodule
`default_nettype wire

// ---- rtl/srp_sync.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module srp_sync
  import srp_pkg::*;
#(
  parameter int unsigned W = 1                // Number of bits synchronised
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // Both stages in one state word; stage one feeds only stage two
  typedef struct packed {
    logic [W-1:0] meta;                       // First stage, may go metastable
    logic [W-1:0] safe;                       // Second stage, safe to read
  } srp_sync_st_t;

  srp_sync_st_t st_ff;                        // Registered state
  srp_sync_st_t nxt_st;                       // Next state

  // Shift the pin level one stage per clock
  always_comb begin
    nxt_st.meta = d_i;
    nxt_st.safe = st_ff.meta;
  end

  // Synchronous reset to a known low level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{meta: {W{SRP_SYNC_RST}}, safe: {W{SRP_SYNC_RST}}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.safe;

endmodule
`default_nettype wire

// ---- testbench/srp_supply_monitor.sv ----
// Behavioural model of the external supply comparators
`timescale 1ns/1ps
`default_nettype none
module srp_supply_monitor #(
  parameter int unsigned MIN_LOW = 3  // Shortest low pulse, in clocks
) (
  // Clock and requests from the bench
  input  wire logic clk_i,
  input  wire logic fail_i,
  input  wire logic warn_i,
  // Comparator outputs
  output logic      fail_n_o,
  output logic      warn_n_o
);
  // Starts loaded so the fail line is low through power-up
  logic [3:0] low_cnt = 4'(MIN_LOW);

  // Stretch every fail pulse so the async clear can see it
  always @(posedge clk_i) begin
    if (fail_i) low_cnt <= 4'(MIN_LOW);
    else if (low_cnt != 4'h0) low_cnt <= low_cnt - 4'h1;
  end
  assign fail_n_o = !(fail_i || low_cnt != 4'h0);
  assign warn_n_o = !warn_i;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench of the reset and power-save controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srp_pkg::*;
  localparam logic [SRP_CNT_W-1:0] LONG_N  = 20'h00028;  // Shortened long delay
  localparam logic [SRP_CNT_W-1:0] SHORT_N = 20'h0000A;  // Shortened short delay
  logic clk = 0, rst = 1, sel = 1, wdog = 0, wr = 0, rd = 0, done = 0, bram = 0;
  logic bus = 0, rds = 0, wrs = 0, fail_req = 1, warn_req = 1, fail_n, warn_n;
  logic [3:0] addr = 4'h0, wake = 4'h0;
  logic [7:0] wdat = 8'h00, gpio = 8'h00, rdat, gpio_oe, inh, v;
  logic core_rst, regs_rst, halt, wirq, bus_oe, rd_o, wr_o, osc, blk, bram_o, rtc, rfreq;
  int failures = 0, checks = 0, cyc = 0, n;

  srp_supply_monitor mon_u (.clk_i(clk), .fail_i(fail_req), .warn_i(warn_req), .fail_n_o(fail_n), .warn_n_o(warn_n));
  srp_reset_power_ctrl #(.LONG_DELAY_CYCLES(LONG_N), .SHORT_DELAY_CYCLES(SHORT_N)) dut_u (
    .CORE_CLK_I(clk), .RST_I(rst), .POWER_FAIL_N_I(fail_n), .POWER_WARNING_N_I(warn_n),
    .RESET_DELAY_SELECT_I(sel), .WATCHDOG_RESET_I(wdog), .REG_ADDR_I(addr), .REG_WDATA_I(wdat),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .WAKE_IRQ_I(wake), .RF_POWER_DOWN_REQ_O(rfreq),
    .RF_POWER_DOWN_DONE_I(done), .CORE_RESET_O(core_rst), .REGS_RESET_O(regs_rst), .CORE_HALT_O(halt),
    .POWER_WARNING_IRQ_O(wirq), .BUS_DRIVE_REQ_I(bus), .RD_STROBE_REQ_I(rds), .WR_STROBE_REQ_I(wrs),
    .GPIO_OE_REQ_I(gpio), .BUS_OE_O(bus_oe), .RD_STROBE_O(rd_o), .WR_STROBE_O(wr_o), .GPIO_OE_O(gpio_oe),
    .OSC_ENABLE_O(osc), .SAMPLE_INPUT_BLOCK_O(blk), .CHANNEL_INHIBIT_O(inh),
    .BACKUP_RAM_SELECT_REQ_N_I(bram), .BACKUP_RAM_SELECT_N_O(bram_o), .RTC_ISOLATE_O(rtc));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdat <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1;
    d = rdat;
  endtask

  // Edge 1 is the first edge with both monitor pins seen high
  task automatic rel_cnt(input int exp);
    n = 0;
    #1;
    while (!(fail_n === 1'b1 && warn_n === 1'b1)) begin @(posedge clk); #1; end
    do begin @(posedge clk); #1; n++; end while (regs_rst !== 1'b0 && n < 1000);
    chk("release", n, exp);
  endtask

  // Random pad requests pass only once released
  task automatic pads(input logic relx);
    @(posedge clk) begin bus <= 1'($urandom); rds <= 1; wrs <= 1; gpio <= 8'($urandom); end
    #1;
    chk("bus_oe", bus_oe, bus & relx);
    chk("strobes", {rd_o, wr_o}, {2{relx}});
    chk("gpio_oe", gpio_oe, gpio & {8{relx}});
    chk("osc", osc, 1);
  endtask

  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(6));
    repeat (16) @(posedge clk);
    rst <= 0;
    pads(0);
    @(posedge clk) begin fail_req <= 0; warn_req <= 0; end
    rel_cnt(LONG_N);
    repeat (60) @(posedge clk);
    #1;
    chk("hold", regs_rst, 0);
    pads(1);
    rd_reg(SRP_REG_STATUS, v);
    chk("status", v, 8'h01);
    rd_reg(4'hF, v);
    chk("unmapped", v, 8'h00);
    v = 8'($urandom);
    wr_reg(SRP_REG_INHIBIT, v);
    chk("inhibit", inh, v);
    @(posedge clk) wdog <= 1;
    #1;
    chk("wdog", {core_rst, regs_rst}, 2'b10);
    @(posedge clk) wdog <= 0;
    wr_reg(SRP_REG_CMD, 8'h01);
    chk("rf_req", {rfreq, blk}, 2'b10);
    @(posedge clk) done <= 1;
    @(posedge clk) done <= 0;
    #1;
    chk("gate", {rfreq, blk}, 2'b01);
    @(posedge clk);
    #1;
    chk("sleep", {halt, rtc}, 2'b10);
    @(posedge clk) wake <= 4'h1 << ($urandom % 4);
    @(posedge clk) wake <= 4'h0;
    #1;
    chk("wake", {halt, blk}, 2'b00);
    wr_reg(SRP_REG_CMD, 8'h02);
    chk("idle", {halt, blk}, 2'b10);
    @(posedge clk) wake <= 4'h8;
    @(posedge clk) wake <= 4'h0;
    #1;
    chk("resume", halt, 0);
    @(posedge clk) begin fail_req <= 1; warn_req <= 1; sel <= 0; end
    #1;
    chk("fail", {core_rst, regs_rst, rtc, bram_o}, 4'hF);
    pads(0);
    @(posedge clk) fail_req <= 0;
    repeat (20) @(posedge clk);
    #1;
    chk("stall", {regs_rst, wirq, inh}, {2'b11, 8'h00});
    @(posedge clk) warn_req <= 0;
    rel_cnt(SHORT_N);
    close_out;
  end
endmodule
`default_nettype wire
